/* verilog/pctd_pkg.sv */
package pctd_pkg;
	localparam logic [3:0] CMD_INT_ACK = 4'h0;
	localparam logic [3:0] CMD_SPECIAL = 4'h1;
	localparam logic [3:0] CMD_IO_RD = 4'h2;
	localparam logic [3:0] CMD_IO_WR = 4'h3;
	localparam logic [3:0] CMD_MEM_RD = 4'h6;
	localparam logic [3:0] CMD_MEM_WR = 4'h7;
	localparam logic [3:0] CMD_CFG_RD = 4'hA;
	localparam logic [3:0] CMD_CFG_WR = 4'hB;
	localparam logic [3:0] CMD_MEM_RD_MUL = 4'hC;
	localparam logic [3:0] CMD_MEM_RD_LINE = 4'hE;
	localparam logic [3:0] CMD_MEM_WR_INV = 4'hF;
	localparam int FIFO_WIDTH = 32;
	localparam int FIFO_DEPTH = 8;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	typedef enum logic [1:0] {
		PCTD_SP_MEM,
		PCTD_SP_IO,
		PCTD_SP_CFG,
		PCTD_SP_NONE
	} pctd_space_e;
endpackage

/* verilog/pctd_fifo.sv */
`timescale 1ns/1ps
module pctd_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0] count_r;
	logic push;
	logic pop;

	assign in_ready = (count_r != (AW+1)'(DEPTH));
	assign out_valid = (count_r != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_ptr_r];

	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
			end
			count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

/* verilog/pctd_target.sv */
`timescale 1ns/1ps
module pctd_target
	import pctd_pkg::*;
#(
	parameter logic [31:0] MEM_BASE = 32'h0000_0000,
	parameter logic [31:0] MEM_MASK = 32'hFFFF_FF00,
	parameter logic [31:0] IO_BASE = 32'h0000_0000,
	parameter logic [31:0] IO_MASK = 32'hFFFF_FFF0,
	parameter logic [31:0] REG_MASK = 32'h0000_0080
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic frame_n,
	input wire logic irdy_n,
	input wire logic idsel,
	input wire logic [3:0] cbe_n,
	input wire logic [31:0] ad_in,
	output logic [31:0] ad_out,
	output logic ad_oe,
	output logic devsel_n_out,
	output logic trdy_n_out,
	output logic stop_n_out,
	output logic ctl_oe,
	output logic [31:0] wr_data,
	output logic wr_valid,
	input wire logic wr_ready,
	input wire logic [31:0] rd_data,
	input wire logic rd_valid,
	output logic rd_ready,
	output logic [31:0] cur_addr,
	output logic [3:0] cur_cmd,
	output logic cur_is_read,
	output logic [1:0] cur_space,
	output logic busy
);
	typedef enum logic [2:0] {
		PCTD_IDLE,
		PCTD_TURN,
		PCTD_DATA,
		PCTD_BACKOFF,
		PCTD_WAIT_IDLE
	} pctd_state_e;

	pctd_state_e state_r;
	logic frame_n_s1_r;
	logic frame_n_s2_r;
	logic frame_n_prev_r;
	logic irdy_n_s1_r;
	logic irdy_n_s2_r;
	logic idsel_s1_r;
	logic idsel_s2_r;
	logic [3:0] cbe_n_s1_r;
	logic [3:0] cbe_n_s2_r;
	logic [31:0] ad_s1_r;
	logic [31:0] ad_s2_r;
	logic [31:0] addr_r;
	logic [3:0] cmd_r;
	logic is_read_r;
	logic burst_ok_r;
	pctd_space_e space_r;
	logic devsel_r;
	logic trdy_r;
	logic stop_r;
	logic oe_r;
	logic ad_oe_r;
	logic [31:0] ad_out_r;
	logic addr_phase;
	logic claim;
	logic xfer;
	logic last;
	logic bus_idle;
	logic [3:0] cmd_in;
	pctd_space_e space_in;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [31:0] fifo_out_data;
	logic fifo_out_ready;

	// fold aliases onto base commands and sort into address spaces
	function automatic logic [3:0] pctd_norm_cmd(input logic [3:0] c);
		unique case (c)
			CMD_MEM_RD_MUL, CMD_MEM_RD_LINE: pctd_norm_cmd = CMD_MEM_RD;
			CMD_MEM_WR_INV: pctd_norm_cmd = CMD_MEM_WR;
			default: pctd_norm_cmd = c;
		endcase
	endfunction

	function automatic pctd_space_e pctd_space(input logic [3:0] c);
		unique case (c)
			CMD_IO_RD, CMD_IO_WR: pctd_space = PCTD_SP_IO;
			CMD_MEM_RD, CMD_MEM_WR: pctd_space = PCTD_SP_MEM;
			CMD_CFG_RD, CMD_CFG_WR: pctd_space = PCTD_SP_CFG;
			default: pctd_space = PCTD_SP_NONE;
		endcase
	endfunction

	// pins are asynchronous to core_clk, so every one takes two stages
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			frame_n_s1_r <= 1'b1;
			frame_n_s2_r <= 1'b1;
			frame_n_prev_r <= 1'b1;
			irdy_n_s1_r <= 1'b1;
			irdy_n_s2_r <= 1'b1;
			idsel_s1_r <= 1'b0;
			idsel_s2_r <= 1'b0;
			cbe_n_s1_r <= 4'hF;
			cbe_n_s2_r <= 4'hF;
			ad_s1_r <= RESET_WORD;
			ad_s2_r <= RESET_WORD;
		end else begin
			frame_n_s1_r <= frame_n;
			frame_n_s2_r <= frame_n_s1_r;
			frame_n_prev_r <= frame_n_s2_r;
			irdy_n_s1_r <= irdy_n;
			irdy_n_s2_r <= irdy_n_s1_r;
			idsel_s1_r <= idsel;
			idsel_s2_r <= idsel_s1_r;
			cbe_n_s1_r <= cbe_n;
			cbe_n_s2_r <= cbe_n_s1_r;
			ad_s1_r <= ad_in;
			ad_s2_r <= ad_s1_r;
		end
	end

	assign addr_phase = frame_n_prev_r && !frame_n_s2_r;
	// the command code stands on the c/be pins as is; no inversion
	assign cmd_in = cbe_n_s2_r;
	assign space_in = pctd_space(pctd_norm_cmd(cmd_in));
	always_comb begin
		unique case (space_in)
			PCTD_SP_MEM: claim = ((ad_s2_r & MEM_MASK) == MEM_BASE);
			PCTD_SP_IO: claim = ((ad_s2_r & IO_MASK) == IO_BASE);
			PCTD_SP_CFG: claim = idsel_s2_r;
			PCTD_SP_NONE: claim = 1'b0;
		endcase
	end
	assign xfer = !trdy_r && !irdy_n_s2_r;
	assign last = xfer && frame_n_s2_r;
	assign bus_idle = frame_n_s2_r && irdy_n_s2_r;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			addr_r <= RESET_WORD;
			cmd_r <= 4'h0;
			is_read_r <= 1'b0;
			burst_ok_r <= 1'b0;
			space_r <= PCTD_SP_NONE;
		end else if (addr_phase && state_r == PCTD_IDLE) begin
			addr_r <= ad_s2_r;
			cmd_r <= pctd_norm_cmd(cmd_in);
			is_read_r <= !cmd_in[0];
			space_r <= space_in;
			// register window and config space refuse bursts
			burst_ok_r <= (space_in != PCTD_SP_CFG) && ((ad_s2_r & REG_MASK) == '0);
		end else if (xfer) begin
			addr_r <= addr_r + 32'h0000_0004;
		end
	end

	// one process drives the bus handshake; target only, never master
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= PCTD_IDLE;
			devsel_r <= 1'b1;
			trdy_r <= 1'b1;
			stop_r <= 1'b1;
			oe_r <= 1'b0;
			ad_oe_r <= 1'b0;
		end else begin
			unique case (state_r)
				PCTD_IDLE: begin
					ad_oe_r <= 1'b0;
					if (addr_phase && claim) begin
						devsel_r <= 1'b0;
						oe_r <= 1'b1;
						state_r <= !cmd_in[0] ? PCTD_TURN : PCTD_DATA;
					end else if (addr_phase) begin
						state_r <= PCTD_WAIT_IDLE;
					end
				end
				PCTD_TURN: begin
					ad_oe_r <= 1'b1;
					state_r <= PCTD_DATA;
				end
				PCTD_DATA: begin
					if (last || (xfer && !stop_r)) begin
						devsel_r <= 1'b1;
						trdy_r <= 1'b1;
						stop_r <= 1'b1;
						ad_oe_r <= 1'b0;
						state_r <= PCTD_BACKOFF;
					end else begin
						// ready only when data can move; waits add single clocks
						trdy_r <= !(is_read_r ? (fifo_out_valid && trdy_r) || (!trdy_r && irdy_n_s2_r)
							: fifo_in_ready);
						if (!frame_n_s2_r && !irdy_n_s2_r && !burst_ok_r) begin
							stop_r <= 1'b0;
						end
					end
				end
				PCTD_BACKOFF: begin
					oe_r <= 1'b0;
					state_r <= bus_idle ? PCTD_IDLE : PCTD_WAIT_IDLE;
				end
				PCTD_WAIT_IDLE: begin
					if (bus_idle) begin
						state_r <= PCTD_IDLE;
					end
				end
				default: state_r <= PCTD_IDLE;
			endcase
		end
	end

	// read data lands in the output register in the clock that trdy is asserted (driven low)
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ad_out_r <= RESET_WORD;
		end else if (fifo_out_ready) begin
			ad_out_r <= fifo_out_data;
		end
	end

	assign fifo_out_ready = is_read_r && state_r == PCTD_DATA && trdy_r && fifo_out_valid
		&& !last;

	pctd_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_rd_fifo (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.in_data(rd_data),
		.in_valid(rd_valid),
		.in_ready(rd_ready),
		.out_data(fifo_out_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready)
	);

	// write path streams directly; full sink holds trdy off
	assign fifo_in_ready = wr_ready;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_data <= RESET_WORD;
			wr_valid <= 1'b0;
		end else begin
			wr_valid <= xfer && !is_read_r && state_r == PCTD_DATA;
			if (xfer && !is_read_r) begin
				wr_data <= ad_s2_r;
			end
		end
	end

	assign ad_out = ad_out_r;
	assign ad_oe = ad_oe_r && is_read_r;
	assign devsel_n_out = devsel_r;
	assign trdy_n_out = trdy_r;
	assign stop_n_out = stop_r;
	assign ctl_oe = oe_r;
	assign cur_addr = addr_r;
	assign cur_cmd = cmd_r;
	assign cur_is_read = is_read_r;
	assign cur_space = space_r;
	assign busy = (state_r != PCTD_IDLE);
endmodule

/* dv/pctd_target_properties.sv */
`timescale 1ns/1ps
module pctd_target_properties
	import pctd_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic frame_n,
	input wire logic irdy_n,
	input wire logic [3:0] cbe_n,
	input wire logic [31:0] ad_in,
	input wire logic ad_oe,
	input wire logic devsel_n_out,
	input wire logic trdy_n_out,
	input wire logic stop_n_out,
	input wire logic ctl_oe,
	input wire logic [3:0] cur_cmd,
	input wire logic cur_is_read
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	AST_RESET_IDLE: assert property (disable iff (1'b0) !reset_n ##1 !reset_n |-> devsel_n_out
		&& trdy_n_out && stop_n_out && !ctl_oe && !ad_oe) else $error("active in reset");
	AST_REFUSE: assert property ($fell(frame_n) && !ctl_oe
		&& (cbe_n inside {4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hD}) |-> devsel_n_out [*8])
		else $error("bad code claimed");
	AST_CLAIM_MEM: assert property ($fell(frame_n) && !ctl_oe && cbe_n == CMD_MEM_RD
		&& ad_in[31:8] == 24'h0 |-> ##[1:6] !devsel_n_out) else $error("no claim");
	AST_TURNAROUND: assert property ($fell(devsel_n_out) && cur_is_read |-> !ad_oe)
		else $error("no turnaround");
	AST_WR_NO_DRIVE: assert property (ad_oe |-> cur_is_read && !devsel_n_out)
		else $error("ad driven");
	AST_RD_KIND: assert property ($fell(devsel_n_out) |-> cur_is_read == !cur_cmd[0])
		else $error("bad kind");
	AST_TRDY_CLAIM: assert property (!trdy_n_out || !stop_n_out |-> !devsel_n_out)
		else $error("trdy without devsel");
	AST_ONE_WORD: assert property (!stop_n_out && !trdy_n_out |=> trdy_n_out)
		else $error("burst continued");
	AST_BACKOFF: assert property ($rose(devsel_n_out) |-> ctl_oe && trdy_n_out
		&& stop_n_out) else $error("no backoff");
	AST_RELEASE: assert property ($rose(devsel_n_out) |=> !ctl_oe)
		else $error("not released");
	AST_IDLE: assert property (frame_n && irdy_n [*5] |-> devsel_n_out)
		else $error("not idle");
endmodule
bind pctd_target pctd_target_properties i_props (.core_clk, .reset_n, .frame_n, .irdy_n,
	.cbe_n, .ad_in, .ad_oe, .devsel_n_out, .trdy_n_out, .stop_n_out, .ctl_oe, .cur_cmd,
	.cur_is_read);

/* dv/pctd_init.sv */
`timescale 1ns/1ps
module pctd_init (
	input wire logic core_clk,
	output logic frame_n,
	output logic irdy_n,
	output logic idsel,
	output logic [3:0] cbe_n,
	output logic [31:0] ad_in,
	input wire logic [31:0] ad_out,
	input wire logic devsel_n_out,
	input wire logic trdy_n_out,
	input wire logic stop_n_out,
	input wire logic ad_oe
);
	logic [31:0] drv = 32'h0;
	logic own = 1'b0;
	logic tgl = 1'b0;
	initial begin
		frame_n = 1'b1;
		irdy_n = 1'b1;
		idsel = 1'b0;
		cbe_n = 4'hF;
	end
	// released lines flip every clock so stale data cannot pass
	always @(posedge core_clk) tgl <= ~tgl;
	assign ad_in = ad_oe ? ad_out : (own ? drv : {16{tgl, ~tgl}});
	task automatic run(input logic [3:0] cmd, input logic [31:0] addr, input logic [31:0] d,
		input logic burst, input logic sel, output int words, output logic [31:0] rdat);
		int n;
		n = 0;
		words = 0;
		rdat = 32'h0;
		@(posedge core_clk);
		frame_n <= 1'b0;
		own <= 1'b1;
		drv <= addr;
		cbe_n <= cmd;
		idsel <= sel;
		@(posedge core_clk);
		frame_n <= ~burst;
		irdy_n <= 1'b0;
		cbe_n <= 4'h0;
		own <= cmd[0];
		drv <= d;
		repeat (40) begin
			@(posedge core_clk);
			if (!irdy_n && !devsel_n_out && !trdy_n_out) begin
				words++;
				rdat = ad_out;
			end
			if (!stop_n_out)
				frame_n <= 1'b1;
			// no claim: end the cycle ourselves
			if ((words > 0 && (frame_n || !stop_n_out)) || (n > 7 && devsel_n_out))
				break;
			n++;
		end
		@(posedge core_clk);
		frame_n <= 1'b1;
		irdy_n <= 1'b1;
		own <= 1'b0;
		idsel <= 1'b0;
	endtask
endmodule

/* dv/pci_target_cycle_decode_test.sv */
`timescale 1ns/1ps
module pci_target_cycle_decode_test;
	import pctd_pkg::*;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic frame_n, irdy_n, idsel, ad_oe, devsel_n_out, trdy_n_out, stop_n_out, ctl_oe;
	logic wr_valid, rd_ready, cur_is_read, cap_rd, dev_q, busy;
	logic [3:0] cur_cmd, cap_cmd;
	logic [1:0] cur_space, cap_space;
	logic wr_ready = 1'b0;
	logic rd_valid = 1'b0;
	logic [3:0] cbe_n;
	logic [15:0] src_idx = 16'h0;
	logic [31:0] ad_in, ad_out, wr_data, cur_addr, rd_data, wr_last, cap_addr;
	int failures = 0;
	int comparisons = 0;
	int wr_cnt = 0;
	int seed = 32'hdc08;
	always #5 core_clk = ~core_clk;
	assign rd_data = {~src_idx, src_idx};
	pctd_target i_dut (.core_clk, .reset_n, .frame_n, .irdy_n, .idsel, .cbe_n, .ad_in, .ad_out,
		.ad_oe, .devsel_n_out, .trdy_n_out, .stop_n_out, .ctl_oe, .wr_data, .wr_valid, .wr_ready,
		.rd_data, .rd_valid, .rd_ready, .cur_addr, .cur_cmd, .cur_is_read, .cur_space,
		.busy);
	pctd_init i_init (.core_clk, .frame_n, .irdy_n, .idsel, .cbe_n, .ad_in, .ad_out,
		.devsel_n_out, .trdy_n_out, .stop_n_out, .ad_oe);
	// source and sink stall at random so the fifo fills and drains
	always @(posedge core_clk) begin
		wr_ready <= ($random(seed) % 3) != 0;
		if (rd_valid && rd_ready)
			src_idx <= src_idx + 16'h1;
		if (!rd_valid || rd_ready)
			rd_valid <= $random(seed) % 2 != 0;
		if (wr_valid) begin
			wr_cnt++;
			wr_last = wr_data;
		end
		if (!devsel_n_out && dev_q) begin
			cap_addr = cur_addr;
			cap_rd = cur_is_read;
			cap_cmd = cur_cmd;
			cap_space = cur_space;
		end
		dev_q = devsel_n_out;
	end
	function automatic logic claimed(input logic [3:0] c, input logic [31:0] a, input logic s);
		case (c)
			CMD_IO_RD, CMD_IO_WR: return a[31:4] == 28'h0;
			CMD_CFG_RD, CMD_CFG_WR: return s;
			CMD_MEM_RD, CMD_MEM_WR, CMD_MEM_RD_MUL, CMD_MEM_RD_LINE, CMD_MEM_WR_INV:
				return a[31:8] == 24'h0;
			default: return 1'b0;
		endcase
	endfunction
	function automatic logic [1:0] space_of(input logic [3:0] c);
		case (c)
			CMD_IO_RD, CMD_IO_WR: return PCTD_SP_IO;
			CMD_CFG_RD, CMD_CFG_WR: return PCTD_SP_CFG;
			CMD_MEM_RD, CMD_MEM_WR, CMD_MEM_RD_MUL, CMD_MEM_RD_LINE, CMD_MEM_WR_INV:
				return PCTD_SP_MEM;
			default: return PCTD_SP_NONE;
		endcase
	endfunction
	// aliases fold onto the plain memory commands
	function automatic logic [3:0] base_cmd(input logic [3:0] c);
		case (c)
			CMD_MEM_RD_MUL, CMD_MEM_RD_LINE: return CMD_MEM_RD;
			CMD_MEM_WR_INV: return CMD_MEM_WR;
			default: return c;
		endcase
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("comparisons=%0d failures=%0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic xact(input logic [3:0] cmd, input logic [31:0] addr, input logic burst);
		int w;
		logic [31:0] r, d;
		logic ok, sel;
		sel = cmd[3:1] == 3'b101 && !addr[9];
		d = $random(seed);
		ok = claimed(cmd, addr, sel);
		wr_cnt = 0;
		cap_addr = 32'h0;
		i_init.run(cmd, addr, d, burst, sel, w, r);
		repeat (8) @(posedge core_clk);
		check(w, {31'h0, ok});
		check(wr_cnt, {31'h0, ok && cmd[0]});
		check({31'h0, busy}, 32'h0);
		if (ok) begin
			check(cap_addr, addr);
			check({31'h0, cap_rd}, {31'h0, !cmd[0]});
			check({28'h0, cap_cmd}, {28'h0, base_cmd(cmd)});
			check({30'h0, cap_space}, {30'h0, space_of(cmd)});
			if (cmd[0])
				check(wr_last, d);
			else
				check({16'h0, r[31:16]}, {16'h0, ~r[15:0]});
		end
		$display("test done cmd=%h addr=%h", cmd, addr);
	endtask
	initial begin
		#200000;
		failures++;
		report_and_stop();
	end
	initial begin
		logic [3:0] cmd;
		repeat (16) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		for (int k = 0; k < 2; k++)
			for (int c = 0; c < 16; c++)
				xact(4'(c), k ? 32'h200 : 32'h4, 1'b0);
		xact(CMD_MEM_WR, 32'h84, 1'b1);
		xact(CMD_MEM_RD_LINE, 32'h80, 1'b1);
		for (int i = 0; i < 20; i++) begin
			cmd = 4'($random(seed));
			xact(cmd, $random(seed) & 32'h17C, 1'b0);
		end
		reset_n <= 1'b0;
		repeat (3) @(posedge core_clk);
		check({devsel_n_out, trdy_n_out, stop_n_out, ctl_oe}, 4'hE);
		reset_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		xact(CMD_IO_RD, 32'h8, 1'b0);
		report_and_stop();
	end
endmodule
